// ===== sim/high_side_driver_control_bench.sv
// self-checking bench for the high-side driver control block
`timescale 1ns/1ps
module high_side_driver_control_bench;
   import hsd_pkg::*;
   localparam int MSK    = 20;
   localparam int SETTLE = 4;
   logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
   logic        stop, special, awready, wready, bvalid, arready, rvalid, irq;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, alt_on, oc, bias, on, fault;
   int          n_errors, cmp_count;
   hsd_top #(.MASK_CNT(MSK)) dut_u (.I_CLK(clk), .I_NRST(nrst),
      .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
      .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(4'hF),
      .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
      .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
      .I_STOP(stop), .I_SPECIAL(special), .I_ALT_ON(alt_on), .I_OC_DET(oc),
      .O_DRV_BIAS(bias), .O_DRV_ON(on), .O_IRQ(irq));
   hsd_stage_model stage_u (.i_bias(bias), .i_on(on), .i_fault(fault),
      .o_oc_det(oc));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", s, exp, got);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // address and data offered together, each released once taken
   task wr(input logic [4:0] a, input logic [7:0] v,
           input logic [1:0] er = RESP_OKAY);
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= {24'h0, v};
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      // late bready exercises the response hold
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask : wr
   task rd(input logic [4:0] a, input logic [7:0] e, input string s,
           input logic [1:0] er = RESP_OKAY);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr  <= a;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clk);
      rready <= 1'b1;
      @(posedge clk);
      rready <= 1'b0;
      chk(s, rdata, {24'h0, e});
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask : rd
   task summarize;
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   // hang guard, far beyond the few hundred cycles of the run
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, stop, special} = 7'h00;
      {awaddr, araddr, wdata, alt_on, fault} = 46'h0;
      {nrst, n_errors, cmp_count} = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rd(5'h04, 8'h00, "config");
      rd(5'h1C, 8'h00, "flags");
      wr(5'h08, 8'hFF, RESP_SLVERR);
      rd(5'h08, 8'h00, "unmapped", RESP_SLVERR);
      wr(5'h0C, 8'hA5);
      rd(5'h0C, 8'h00, "test");
      special <= 1'b1;
      wr(5'h0C, 8'hA5);
      rd(5'h0C, 8'hA5, "test");
      wr(5'h0C, 8'h00);
      special <= 1'b0;
      wr(5'h04, 8'h31);
      rd(5'h04, 8'h31, "config");
      wr(5'h04, 8'h03);
      rd(5'h04, 8'h13, "config");
      chk("bias", {30'h0, bias}, 32'h3);
      wt(SETTLE);
      fault <= 2'h3;
      wr(5'h00, 8'h03);
      wt(8);
      rd(5'h1C, 8'h02, "flags");
      chk("on", {30'h0, on}, 32'h1);
      wt(MSK);
      rd(5'h1C, 8'h03, "flags");
      chk("on", {30'h0, on}, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(5'h18, 8'h80);
      wt(2);
      chk("irq", {31'h0, irq}, 32'h1);
      rd(5'h18, 8'h80, "irq_en");
      stop <= 1'b1;
      wt(3);
      chk("irq", {31'h0, irq}, 32'h0);
      chk("bias", {30'h0, bias}, 32'h0);
      rd(5'h1C, 8'h03, "flags");
      rd(5'h00, 8'h00, "data");
      stop  <= 1'b0;
      fault <= 2'h0;
      wr(5'h1C, 8'h00);
      rd(5'h1C, 8'h03, "flags");
      wr(5'h1C, 8'h01);
      rd(5'h1C, 8'h02, "flags");
      wr(5'h00, 8'h01);
      wt(3);
      chk("on", {30'h0, on}, 32'h1);
      wr(5'h1C, 8'h02);
      wt(3);
      chk("irq", {31'h0, irq}, 32'h0);
      wr(5'h10, 8'h02);
      rd(5'h10, 8'h02, "source");
      alt_on <= 2'h2;
      wt(4);
      chk("on", {30'h0, on}, 32'h3);
      alt_on <= 2'h0;
      wt(4);
      chk("on", {30'h0, on}, 32'h1);
      summarize();
   end
endmodule : high_side_driver_control_bench
bind hsd_top hsd_monitor #(.MASK_CNT(MASK_CNT)) mon_u (.I_CLK(I_CLK),
   .I_NRST(I_NRST), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
   .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
   .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID),
   .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
   .O_RDATA(O_RDATA), .I_STOP(I_STOP), .I_OC_DET(I_OC_DET),
   .O_DRV_BIAS(O_DRV_BIAS), .O_DRV_ON(O_DRV_ON), .O_IRQ(O_IRQ));

// ===== sim/hsd_monitor.sv
// port-level assertions for the high-side driver control block
`timescale 1ns/1ps
module hsd_monitor #(
   parameter int MASK_CNT = 4
) (
   // clock, reset, bus
   input wire logic        I_CLK,
   input wire logic        I_NRST,
   input wire logic        I_AWVALID,
   input wire logic        O_AWREADY,
   input wire logic        I_WVALID,
   input wire logic        O_WREADY,
   input wire logic        O_BVALID,
   input wire logic        I_BREADY,
   input wire logic [1:0]  O_BRESP,
   input wire logic        I_ARVALID,
   input wire logic        O_ARREADY,
   input wire logic        O_RVALID,
   input wire logic        I_RREADY,
   input wire logic [31:0] O_RDATA,
   // mode and output stage
   input wire logic        I_STOP,
   input wire logic [1:0]  I_OC_DET,
   input wire logic [1:0]  O_DRV_BIAS,
   input wire logic [1:0]  O_DRV_ON,
   input wire logic        O_IRQ
);
   // window plus sync, flag and output stages, with slack
   localparam int LIM = MASK_CNT + 8;
   logic [15:0] run_ff [2];
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);
   // cycles a driver has stayed on into an over-current
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         run_ff[0] <= 16'h0;
         run_ff[1] <= 16'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            run_ff[i] <= (O_DRV_ON[i] && I_OC_DET[i]) ?
                         run_ff[i] + 16'h1 : 16'h0;
         end
      end
   end
   a_irq_run_only:
      assert property (O_IRQ |-> !$past(I_STOP)) else $error("irq in stop");
   a_bias_stop:
      assert property (I_STOP |=> O_DRV_BIAS == 2'h0)
         else $error("bias in stop");
   a_drive_stop:
      assert property (I_STOP [*2] |=> O_DRV_ON == 2'h0)
         else $error("on in stop");
   a_oc_shutdown:
      assert property (run_ff[0] <= LIM && run_ff[1] <= LIM)
         else $error("driver not shut down");
   a_b_hold:
      assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
         else $error("write response dropped");
   a_r_hold:
      assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
         else $error("read data dropped");
   a_read_answer:
      assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
         else $error("no rvalid");
   a_read_block:
      assert property (O_RVALID |-> !O_ARREADY)
         else $error("arready while busy");
   a_write_answer:
      assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
         && !O_BVALID |-> ##[1:2] O_BVALID) else $error("no bvalid");
   a_rdata_upper:
      assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
         else $error("upper bits");
   c_irq: cover property (O_IRQ);
   c_slverr: cover property (O_BVALID && O_BRESP == 2'h2);
   c_both_on: cover property (O_DRV_ON == 2'h3);
endmodule : hsd_monitor

// ===== sim/hsd_stage_model.sv
// output stage: comparator trips while biased, on and overloaded
`timescale 1ns/1ps
module hsd_stage_model (
   // from the control block and the bench
   input  wire logic [1:0] i_bias,
   input  wire logic [1:0] i_on,
   input  wire logic [1:0] i_fault,
   // comparator outputs, asynchronous
   output logic      [1:0] o_oc_det
);
   // no current flows unless the switch is biased and on
   assign o_oc_det = i_bias & i_on & i_fault;
endmodule : hsd_stage_model

// ===== verilog/hsd_chan.sv
// one driver channel: sync, mask window, flag and gate
`timescale 1ns/1ps
module hsd_chan #(
   parameter int MASK_CNT = hsd_pkg::MASK_CYCLES
) (
   // clock and reset
   input  wire logic   i_clk,
   input  wire logic   i_nrst,
   // channel bundle
   hsd_drv_if.chan     drv
);
   import hsd_pkg::*;
   localparam int CW = $clog2(MASK_CNT + 1);
   localparam logic [CW-1:0] CNT_ZERO = '0;
   localparam logic [CW-1:0] CNT_LOAD = CW'(MASK_CNT);

   logic          sync1_ff;
   logic          sync2_ff;
   logic          on_prev_ff;
   logic [CW-1:0] mask_cnt_ff;
   logic          flag_ff;
   logic          gate_ff;
   logic          want_on;
   logic          oc_seen;
   logic          mask_start;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= drv.oc_async;
         sync2_ff <= sync1_ff;
      end
   end

   // command bit (data or alternate source) drives on, gated by enable and stop
   assign want_on = drv.cmd_on & drv.enable & ~drv.stop;

   assign mask_start = want_on & ~on_prev_ff & drv.mask_en;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         on_prev_ff  <= 1'b0;
         mask_cnt_ff <= CNT_ZERO;
      end else begin
         on_prev_ff <= want_on;
         if (mask_start)
            mask_cnt_ff <= CNT_LOAD;
         else if (!want_on)
            mask_cnt_ff <= CNT_ZERO;
         else if (mask_cnt_ff != CNT_ZERO)
            mask_cnt_ff <= mask_cnt_ff - 1'b1;
      end
   end

   // ignore during window; only judged while driving
   assign oc_seen = sync2_ff & want_on & drv.enable
                    & (mask_cnt_ff == CNT_ZERO) & ~mask_start;

   // set wins over clear, stop leaves flag alone
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         flag_ff <= 1'b0;
      else if (oc_seen)
         flag_ff <= 1'b1;
      else if (drv.flag_clr)
         flag_ff <= 1'b0;
   end

   // flag forces off; release on clear
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         gate_ff <= 1'b0;
      else
         gate_ff <= want_on & ~flag_ff & ~oc_seen;
   end

   assign drv.flag = flag_ff;
   assign drv.gate = gate_ff;
endmodule : hsd_chan

// ===== verilog/hsd_drv_if.sv
// per-driver signal bundle between the top and the channel module
`timescale 1ns/1ps
interface hsd_drv_if;
   logic enable;
   logic mask_en;
   logic cmd_on;
   logic stop;
   logic oc_async;
   logic flag_clr;
   logic flag;
   logic gate;
   modport chan (input enable, mask_en, cmd_on, stop, oc_async, flag_clr,
                 output flag, gate);
   modport ctrl (output enable, mask_en, cmd_on, stop, oc_async, flag_clr,
                 input flag, gate);
endinterface : hsd_drv_if

// ===== verilog/hsd_pkg.sv
// constants shared by the high-side driver control block
// Operation
// - enable bits 1-0 bias each driver
// - mask enable bits 5-4 suppress shutdown window
// - mask bit writable only while driver disabled
// - configuration register resets to zero
// - test register writable only in special mode
// - irq enable bit 7 gates flag request
// - over-current event sets its flag
// - set flag forces its driver off
// - cleared flag returns control to source
// - write one clears flag, zero no effect
// - masked window ignores detection entirely
// - interrupt raised only in run mode
// - stop mode leaves flags unchanged
// - command from register bit or timer
// - two drivers sharing one irq enable
// - data bit one turns driver on
// - stop clears data bits, drivers off
package hsd_pkg;
   localparam int          NUM_DRV      = 2;
   localparam int          ADDR_W       = 5;
   // register indices as printed; byte address is four times the index
   localparam logic [2:0]  IDX_DATA     = 3'h0;
   localparam logic [2:0]  IDX_CONFIG   = 3'h1;
   localparam logic [2:0]  IDX_TEST     = 3'h3;
   localparam logic [2:0]  IDX_IRQ_EN   = 3'h6;
   localparam logic [2:0]  IDX_FLAG     = 3'h7;
   localparam logic [2:0]  IDX_SOURCE   = 3'h4;
   // field positions
   localparam int          CFG_EN_LSB   = 0;
   localparam int          CFG_MASK_LSB = 4;
   localparam int          IRQ_EN_BIT   = 7;
   // reset values
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [1:0]  RST_PAIR     = 2'h0;
   // axi responses
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // mask window, time in ns and derived cycles at 200 MHz
   localparam int          CLK_PERIOD_NS  = 5;
   localparam int          MASK_WINDOW_NS = 1000;
   localparam int          MASK_CYCLES    =
      (MASK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : hsd_pkg

// ===== verilog/hsd_top.sv
// high-side driver control: axi4-lite registers and two channels
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module hsd_top #(
   parameter int MASK_CNT = hsd_pkg::MASK_CYCLES
) (
   // clock and reset
   input  wire logic                       I_CLK,
   input  wire logic                       I_NRST,
   // axi4-lite write address and data
   input  wire logic                       I_AWVALID,
   output logic                            O_AWREADY,
   input  wire logic [hsd_pkg::ADDR_W-1:0] I_AWADDR,
   input  wire logic                       I_WVALID,
   output logic                            O_WREADY,
   input  wire logic [31:0]                I_WDATA,
   input  wire logic [3:0]                 I_WSTRB,
   // axi4-lite write response
   output logic                            O_BVALID,
   input  wire logic                       I_BREADY,
   output logic [1:0]                      O_BRESP,
   // axi4-lite read
   input  wire logic                       I_ARVALID,
   output logic                            O_ARREADY,
   input  wire logic [hsd_pkg::ADDR_W-1:0] I_ARADDR,
   output logic                            O_RVALID,
   input  wire logic                       I_RREADY,
   output logic [31:0]                     O_RDATA,
   output logic [1:0]                      O_RRESP,
   // system mode
   input  wire logic                       I_STOP,
   input  wire logic                       I_SPECIAL,
   // gate sources from timers or pwm
   input  wire logic [hsd_pkg::NUM_DRV-1:0] I_ALT_ON,
   // output stage
   input  wire logic [hsd_pkg::NUM_DRV-1:0] I_OC_DET,
   output logic [hsd_pkg::NUM_DRV-1:0]      O_DRV_BIAS,
   output logic [hsd_pkg::NUM_DRV-1:0]      O_DRV_ON,
   // interrupt request
   output logic                            O_IRQ
);
   import hsd_pkg::*;

   // registers
   logic [NUM_DRV-1:0] data_ff;
   logic [NUM_DRV-1:0] en_ff;
   logic [NUM_DRV-1:0] mask_ff;
   logic [NUM_DRV-1:0] src_alt_ff;
   logic [7:0]         test_ff;
   logic               irq_en_ff;
   logic [NUM_DRV-1:0] flag;
   logic [NUM_DRV-1:0] gate;
   logic [NUM_DRV-1:0] flag_clr;
   logic [NUM_DRV-1:0] bias_ff;
   logic [NUM_DRV-1:0] on_ff;
   logic               irq_ff;

   // bus slave state
   logic               awready_ff;
   logic               wready_ff;
   logic               arready_ff;
   logic [2:0]         aw_idx_ff;
   logic [7:0]         wdata_ff;
   logic               wstrb0_ff;
   logic               bvalid_ff;
   logic [1:0]         bresp_ff;
   logic               rvalid_ff;
   logic [31:0]        rdata_ff;
   logic [1:0]         rresp_ff;
   logic               wr_go;
   logic               wr_ok;
   logic               wr_en;
   logic [7:0]         rd_byte;
   logic               rd_ok;
   logic [2:0]         ar_idx;

   // write address capture; held until the write commits
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         awready_ff <= 1'b1;
         aw_idx_ff  <= IDX_DATA;
      end else if (I_AWVALID && awready_ff) begin
         awready_ff <= 1'b0;
         aw_idx_ff  <= I_AWADDR[4:2];
      end else if (wr_go) begin
         awready_ff <= 1'b1;
      end
   end

   // write data capture; only the low byte reaches a register
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         wready_ff <= 1'b1;
         wdata_ff  <= RST_BYTE;
         wstrb0_ff <= 1'b0;
      end else if (I_WVALID && wready_ff) begin
         wready_ff <= 1'b0;
         wdata_ff  <= I_WDATA[7:0];
         wstrb0_ff <= I_WSTRB[0];
      end else if (wr_go) begin
         wready_ff <= 1'b1;
      end
   end

   // readies are flops of their own, so the ports carry no gate
   assign O_AWREADY = awready_ff;
   assign O_WREADY  = wready_ff;

   // commit once both halves are held and no response pending
   assign wr_go = ~awready_ff & ~wready_ff & ~bvalid_ff;
   always_comb begin
      unique case (aw_idx_ff)
         IDX_DATA, IDX_CONFIG, IDX_TEST,
         IDX_IRQ_EN, IDX_FLAG, IDX_SOURCE: wr_ok = 1'b1;
         default:                          wr_ok = 1'b0;
      endcase
   end
   assign wr_en = wr_go & wr_ok & wstrb0_ff;

   // write response valid, held until the master takes it
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         bvalid_ff <= 1'b0;
      else if (wr_go)
         bvalid_ff <= 1'b1;
      else if (I_BREADY)
         bvalid_ff <= 1'b0;
   end

   // response code, decided at commit and held with bvalid
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         bresp_ff <= RESP_OKAY;
      else if (wr_go)
         bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
   end
   assign O_BVALID = bvalid_ff;
   assign O_BRESP  = bresp_ff;

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         en_ff <= RST_PAIR;
      end else if (wr_en && aw_idx_ff == IDX_CONFIG) begin
         en_ff <= wdata_ff[CFG_EN_LSB +: NUM_DRV];
      end
   end

   // mask bit held while its driver enabled
   // old enable decides, so enabling and masking at once keeps mask
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         mask_ff <= RST_PAIR;
      end else if (wr_en && aw_idx_ff == IDX_CONFIG) begin
         for (int i = 0; i < NUM_DRV; i++)
            if (!en_ff[i])
               mask_ff[i] <= wdata_ff[CFG_MASK_LSB + i];
      end
   end

   // stop clears data bits; enables kept for return
   // stop wins over a software write landing in the same cycle
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         data_ff <= RST_PAIR;
      else if (I_STOP)
         data_ff <= RST_PAIR;
      else if (wr_en && aw_idx_ff == IDX_DATA)
         data_ff <= wdata_ff[NUM_DRV-1:0];
   end

   // gate source select, stands in for the routing unit
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         src_alt_ff <= RST_PAIR;
      else if (wr_en && aw_idx_ff == IDX_SOURCE)
         src_alt_ff <= wdata_ff[NUM_DRV-1:0];
   end

   // test register only in special mode
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         test_ff <= RST_BYTE;
      else if (wr_en && aw_idx_ff == IDX_TEST && I_SPECIAL)
         test_ff <= wdata_ff;
   end

   // shared interrupt enable
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         irq_en_ff <= 1'b0;
      else if (wr_en && aw_idx_ff == IDX_IRQ_EN)
         irq_en_ff <= wdata_ff[IRQ_EN_BIT];
   end

   // flag clear pulses from a write of ones
   always_comb begin
      if (wr_en && aw_idx_ff == IDX_FLAG)
         flag_clr = wdata_ff[NUM_DRV-1:0];
      else
         flag_clr = RST_PAIR;
   end

   for (genvar g = 0; g < NUM_DRV; g++) begin : g_chan
      hsd_drv_if dif ();
      assign dif.cmd_on   = src_alt_ff[g] ? I_ALT_ON[g] : data_ff[g];
      assign dif.enable   = en_ff[g];
      assign dif.mask_en  = mask_ff[g];
      assign dif.stop     = I_STOP;
      assign dif.oc_async = I_OC_DET[g];
      assign dif.flag_clr = flag_clr[g];
      assign flag[g]      = dif.flag;
      assign gate[g]      = dif.gate;
      hsd_chan #(
         .MASK_CNT (MASK_CNT)
      ) u_chan (
         .i_clk  (I_CLK),
         .i_nrst (I_NRST),
         .drv    (dif)
      );
   end

   // bias drops in stop, restored from the kept enables after
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         bias_ff <= RST_PAIR;
      else
         bias_ff <= I_STOP ? RST_PAIR : en_ff;
   end

   // gate registered once more so the pin comes from a flop
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         on_ff <= RST_PAIR;
      else
         on_ff <= gate;
   end
   assign O_DRV_BIAS = bias_ff;
   assign O_DRV_ON   = on_ff;

   // enable gates flags; run mode only
   // registered, so the request trails the flag by one cycle
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST)
         irq_ff <= 1'b0;
      else
         irq_ff <= irq_en_ff & (|flag) & ~I_STOP;
   end
   assign O_IRQ = irq_ff;

   // read mux, decoded straight from the address; no wait state
   assign ar_idx = I_ARADDR[4:2];
   always_comb begin
      rd_ok   = 1'b1;
      rd_byte = RST_BYTE;
      unique case (ar_idx)
         IDX_DATA:   rd_byte[NUM_DRV-1:0] = data_ff;
         IDX_CONFIG: begin
            rd_byte[CFG_EN_LSB +: NUM_DRV]   = en_ff;
            rd_byte[CFG_MASK_LSB +: NUM_DRV] = mask_ff;
         end
         IDX_TEST:   rd_byte = test_ff;
         IDX_SOURCE: rd_byte[NUM_DRV-1:0] = src_alt_ff;
         IDX_IRQ_EN: rd_byte[IRQ_EN_BIT] = irq_en_ff;
         IDX_FLAG:   rd_byte[NUM_DRV-1:0] = flag;
         default:    rd_ok = 1'b0;
      endcase
   end

   // read handshake, one cycle from address to data; arready is
   // its own flop and always the inverse of rvalid
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end else if (I_ARVALID && arready_ff) begin
         rvalid_ff  <= 1'b1;
         arready_ff <= 1'b0;
      end else if (I_RREADY) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // read payload, latched with the address and held until taken
   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (I_ARVALID && arready_ff) begin
         rdata_ff <= {24'h00_0000, rd_byte};
         rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
   end
   assign O_ARREADY = arready_ff;
   assign O_RVALID  = rvalid_ff;
   assign O_RDATA   = rdata_ff;
   assign O_RRESP   = rresp_ff;
endmodule : hsd_top
